// file: design/nac_pkg.sv
// package for the nvm access and command strobe register group
// assumes a single 20 MHz clock domain and a plain register port
package nac_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] NAC_ADDR_WORD   = 8'h0B;
    localparam logic [7:0] NAC_ADDR_RDATA  = 8'h0C;
    localparam logic [7:0] NAC_ADDR_STAT   = 8'h0E;
    localparam logic [7:0] NAC_ADDR_CMD    = 8'h10;
    localparam logic [7:0] NAC_ADDR_IRQST  = 8'h20;
    localparam logic [7:0] NAC_ADDR_IRQMSK = 8'h21;
    localparam logic [7:0] NAC_RESET_BYTE  = 8'h00;
    localparam int NAC_WORD_ADDR_MSB       = 6;
    localparam int NAC_STAT_BUSY_BIT       = 3;
    localparam int NAC_STAT_READ_BIT       = 2;
    // ************************************************************
    // command bits
    // ************************************************************
    localparam int NAC_CMD_MEASURE  = 7;
    localparam int NAC_CMD_ARMCLR   = 6;
    localparam int NAC_CMD_CCCLR    = 5;
    localparam int NAC_CMD_CAL      = 4;
    localparam int NAC_CMD_RELOAD   = 2;
    localparam int NAC_CMD_FULLRST  = 0;
    // ************************************************************
    // interrupt status bits
    // ************************************************************
    localparam int NAC_IRQ_READ_DONE   = 0;
    localparam int NAC_IRQ_RELOAD_DONE = 1;
    localparam int NAC_IRQ_WIDTH       = 2;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int NAC_CLK_HZ          = 20_000_000;
    localparam int NAC_LOAD_MAX_US     = 400;
    localparam int NAC_LOAD_CYCLES     = NAC_LOAD_MAX_US * (NAC_CLK_HZ / 1_000_000);
    localparam int NAC_READ_NS         = 200;
    localparam int NAC_READ_CYCLES     = (NAC_READ_NS * (NAC_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int NAC_CNT_W           = 14;

    typedef enum {NAC_IDLE, NAC_READ, NAC_CLEAR, NAC_LOAD} nac_state_e;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nac_bus_s;

    typedef struct packed {
        logic measureStart;
        logic resultClearArm;
        logic chargeCountClear;
        logic chargeCalibrationStart;
        logic defaultsReload;
        logic fullReset;
    } nac_cmd_s;
endpackage

// file: design/nac_regs.sv
// nvm access, status and command strobe register group
// assumes host register port on the same clock; nvm array answers in fixed time
//
// Summary of operation
// - a 7-bit read-write nvm word address sits in the low bits of the address register.
// - the read-only data register shows the last nvm read word and resets to zero.
// - setting the read command bit starts a read and the busy flag stays high until it ends.
// - writing one to command bit 7 starts exactly one supply measurement.
// - command bit 6 arms loading of the next conversion into all three 12-bit results.
// - writing one to command bit 5 zeroes all charge counters.
// - writing one to command bit 4 starts charge counter calibration.
// - writing one to command bit 2 rereads the nvm and restores control register defaults.
// - during a defaults reload from command bit 2 alone, converters enabled by default stay enabled throughout.
// - writing one to command bit 0 clears all registers like a brownout, then reloads defaults.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module nac_regs
#(
    parameter int LOAD_CYCLES = nac_pkg::NAC_LOAD_CYCLES
)
(
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire nac_pkg::nac_bus_s bus,
    output logic [7:0]            rdata,
    output nac_pkg::nac_cmd_s     cmd,
    output logic                  nvmReadReq,
    output logic [6:0]            nvmAddr,
    input  wire logic [7:0]       nvmData,
    output logic                  regsClear,
    output logic                  defaultsLoading,
    output logic                  modesHeldOff,
    output logic                  irq
);
    import nac_pkg::*;

    // ************************************************************
    // reset release
    // ************************************************************
    logic rstSync1;
    logic rstSync2;
    logic rstN;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end
        else
        begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end
    assign rstN = rstSync2;

    // ************************************************************
    // decode
    // ************************************************************
    logic wrWord;
    logic wrStat;
    logic wrCmd;
    logic wrIrqSt;
    logic wrIrqMsk;
    logic readGo;
    logic fullGo;
    logic reloadGo;

    assign wrWord   = bus.write && (bus.addr == NAC_ADDR_WORD);
    assign wrStat   = bus.write && (bus.addr == NAC_ADDR_STAT);
    assign wrCmd    = bus.write && (bus.addr == NAC_ADDR_CMD);
    assign wrIrqSt  = bus.write && (bus.addr == NAC_ADDR_IRQST);
    assign wrIrqMsk = bus.write && (bus.addr == NAC_ADDR_IRQMSK);
    assign readGo   = wrStat && bus.wdata[NAC_STAT_READ_BIT];
    assign fullGo   = wrCmd && bus.wdata[NAC_CMD_FULLRST];
    assign reloadGo = wrCmd && bus.wdata[NAC_CMD_RELOAD];

    // ************************************************************
    // nvm sequencer
    // ************************************************************
    nac_state_e            state_reg;
    logic [NAC_CNT_W-1:0]  count_reg;
    logic [7:0]            readData_reg;
    logic [6:0]            wordAddr_reg;
    logic                  busy;
    logic                  readDone;
    logic                  loadDone;
    logic                  holdModes_reg;

    assign busy     = (state_reg != NAC_IDLE);
    assign readDone = (state_reg == NAC_READ) && (count_reg == '0);
    assign loadDone = (state_reg == NAC_LOAD) && (count_reg == '0);

    // full reset wins over a reload or read issued in the same write
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            state_reg <= NAC_IDLE;
            count_reg <= '0;
        end
        else
        begin
            case (state_reg)
                NAC_IDLE:
                begin
                    if (fullGo)
                    begin
                        state_reg <= NAC_CLEAR;
                    end
                    else if (reloadGo)
                    begin
                        state_reg <= NAC_LOAD;
                        count_reg <= NAC_CNT_W'(LOAD_CYCLES - 1);
                    end
                    else if (readGo)
                    begin
                        state_reg <= NAC_READ;
                        count_reg <= NAC_CNT_W'(NAC_READ_CYCLES - 1);
                    end
                end
                NAC_READ:
                begin
                    if (count_reg == '0)
                        state_reg <= NAC_IDLE;
                    else
                        count_reg <= count_reg - 1'b1;
                end
                NAC_CLEAR:
                begin
                    state_reg <= NAC_LOAD;
                    count_reg <= NAC_CNT_W'(LOAD_CYCLES - 1);
                end
                NAC_LOAD:
                begin
                    if (count_reg == '0)
                        state_reg <= NAC_IDLE;
                    else
                        count_reg <= count_reg - 1'b1;
                end
                default:
                begin
                    state_reg <= NAC_IDLE;
                end
            endcase
        end
    end

    // read, reload and full reset commands arriving while busy are dropped; software must poll busy first
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            readData_reg <= NAC_RESET_BYTE;
        else if (state_reg == NAC_CLEAR)
            readData_reg <= NAC_RESET_BYTE;
        else if (readDone)
            readData_reg <= nvmData;
    end

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            wordAddr_reg <= '0;
        else if (state_reg == NAC_CLEAR)
            wordAddr_reg <= '0;
        else if (wrWord)
            wordAddr_reg <= bus.wdata[NAC_WORD_ADDR_MSB:0];
    end

    assign nvmAddr         = wordAddr_reg;
    assign nvmReadReq      = (state_reg == NAC_READ);
    assign regsClear       = (state_reg == NAC_CLEAR);
    assign defaultsLoading = (state_reg == NAC_LOAD);
    // a reload leaves modes untouched so enabled converters stay up
    assign modesHeldOff    = (state_reg == NAC_CLEAR)
                             || ((state_reg == NAC_LOAD) && holdModes_reg);

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            holdModes_reg <= 1'b0;
        else if (state_reg == NAC_CLEAR)
            holdModes_reg <= 1'b1;
        else if (state_reg == NAC_IDLE)
            holdModes_reg <= 1'b0;
    end

    // ************************************************************
    // command strobes
    // ************************************************************
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            cmd <= '0;
        else
        begin
            cmd.measureStart           <= wrCmd && bus.wdata[NAC_CMD_MEASURE];
            cmd.resultClearArm         <= wrCmd && bus.wdata[NAC_CMD_ARMCLR];
            cmd.chargeCountClear       <= wrCmd && bus.wdata[NAC_CMD_CCCLR];
            cmd.chargeCalibrationStart <= wrCmd && bus.wdata[NAC_CMD_CAL];
            cmd.defaultsReload         <= reloadGo && !fullGo && !busy;
            cmd.fullReset              <= fullGo && !busy;
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    logic [NAC_IRQ_WIDTH-1:0] irqStat_reg;
    logic [NAC_IRQ_WIDTH-1:0] irqMask_reg;
    logic [NAC_IRQ_WIDTH-1:0] irqEvent;

    assign irqEvent = {loadDone, readDone};

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            irqStat_reg <= '0;
        else if (state_reg == NAC_CLEAR)
            irqStat_reg <= '0;
        else
            irqStat_reg <= (irqStat_reg & ~({NAC_IRQ_WIDTH{wrIrqSt}}
                           & bus.wdata[NAC_IRQ_WIDTH-1:0])) | irqEvent;
    end

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            irqMask_reg <= '0;
        else if (state_reg == NAC_CLEAR)
            irqMask_reg <= '0;
        else if (wrIrqMsk)
            irqMask_reg <= bus.wdata[NAC_IRQ_WIDTH-1:0];
    end

    assign irq = |(irqStat_reg & irqMask_reg);

    // ************************************************************
    // read port
    // ************************************************************
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            rdata <= NAC_RESET_BYTE;
        else if (bus.read)
        begin
            case (bus.addr)
                NAC_ADDR_WORD:   rdata <= {1'b0, wordAddr_reg};
                NAC_ADDR_RDATA:  rdata <= readData_reg;
                NAC_ADDR_STAT:   rdata <= {4'h0, busy, nvmReadReq, 2'h0};
                NAC_ADDR_IRQST:  rdata <= {6'h00, irqStat_reg};
                NAC_ADDR_IRQMSK: rdata <= {6'h00, irqMask_reg};
                default:         rdata <= NAC_RESET_BYTE;
            endcase
        end
        else
            rdata <= NAC_RESET_BYTE;
    end

    // ************************************************************
    // checks
    // ************************************************************
    // repetition count must stay literal: four read cycles at 20 MHz
    busy_after_read_a: assert property (@(posedge clock) disable iff (!rstN)
        (readGo && !busy) |=> busy [*4] ##1 !busy)
        else $error("busy does not span the nvm read");
    data_capture_a: assert property (@(posedge clock) disable iff (!rstN)
        readDone |=> (readData_reg == $past(nvmData)))
        else $error("read data not captured");
    addr_write_a: assert property (@(posedge clock) disable iff (!rstN)
        (wrWord && !fullGo && !busy) |=> (nvmAddr == $past(bus.wdata[6:0])))
        else $error("address not stored");
    measure_pulse_a: assert property (@(posedge clock) disable iff (!rstN)
        cmd.measureStart |=> !cmd.measureStart || $past(wrCmd && bus.wdata[7]))
        else $error("measure strobe held");
    ccclr_pulse_a: assert property (@(posedge clock) disable iff (!rstN)
        (wrCmd && bus.wdata[5]) |=> cmd.chargeCountClear)
        else $error("counter clear missing");
    cal_pulse_a: assert property (@(posedge clock) disable iff (!rstN)
        (wrCmd && bus.wdata[4]) |=> cmd.chargeCalibrationStart)
        else $error("calibration start missing");
    arm_pulse_a: assert property (@(posedge clock) disable iff (!rstN)
        (wrCmd && bus.wdata[6]) |=> cmd.resultClearArm)
        else $error("result clear arm missing");
    reload_keep_a: assert property (@(posedge clock) disable iff (!rstN)
        (reloadGo && !fullGo && !busy) |=> defaultsLoading && !modesHeldOff)
        else $error("reload disturbed converter modes");
    full_reset_a: assert property (@(posedge clock) disable iff (!rstN)
        (fullGo && !busy) |=> regsClear ##1 (defaultsLoading && modesHeldOff))
        else $error("full reset sequence wrong");
    cmd_reads_zero_a: assert property (@(posedge clock) disable iff (!rstN)
        (bus.read && bus.addr == NAC_ADDR_CMD) |=> (rdata == 8'h00))
        else $error("command register read not zero");
    cover_read_c: cover property (@(posedge clock) disable iff (!rstN) readDone);
    cover_reload_c: cover property (@(posedge clock) disable iff (!rstN) cmd.defaultsReload);
    cover_full_c: cover property (@(posedge clock) disable iff (!rstN) loadDone && holdModes_reg);
    cover_measure_c: cover property (@(posedge clock) disable iff (!rstN) cmd.measureStart);
    cover_irq_c: cover property (@(posedge clock) disable iff (!rstN) irq);
    clear_one_cycle_a: assert property (@(posedge clock) disable iff (!rstN)
        regsClear |=> !regsClear)
        else $error("clear step longer than one cycle");
    clear_wipes_a: assert property (@(posedge clock) disable iff (!rstN)
        regsClear |=> (nvmAddr == '0) && (readData_reg == NAC_RESET_BYTE)
            && (irqMask_reg == '0))
        else $error("full reset left registers set");
    full_wins_a: assert property (@(posedge clock) disable iff (!rstN)
        (fullGo && reloadGo && !busy) |=> regsClear && !cmd.defaultsReload)
        else $error("reload issued beside full reset");
    reload_pulse_a: assert property (@(posedge clock) disable iff (!rstN)
        (reloadGo && !fullGo && !busy) |=> cmd.defaultsReload && !cmd.fullReset)
        else $error("reload strobe wrong");
    status_busy_a: assert property (@(posedge clock) disable iff (!rstN)
        (bus.read && bus.addr == NAC_ADDR_STAT) |=> (rdata[NAC_STAT_BUSY_BIT] == $past(busy)))
        else $error("busy flag misreported");
    rdata_read_a: assert property (@(posedge clock) disable iff (!rstN)
        (bus.read && bus.addr == NAC_ADDR_RDATA) |=> (rdata == $past(readData_reg)))
        else $error("data register misreported");
    rdata_idle_a: assert property (@(posedge clock) disable iff (!rstN)
        !bus.read |=> (rdata == NAC_RESET_BYTE))
        else $error("read data outside a read");
    read_event_a: assert property (@(posedge clock) disable iff (!rstN)
        readDone |=> irqStat_reg[NAC_IRQ_READ_DONE])
        else $error("read done flag not set");
    irq_clear_a: assert property (@(posedge clock) disable iff (!rstN)
        (wrIrqSt && bus.wdata[NAC_IRQ_READ_DONE] && !readDone && !regsClear)
            |=> !irqStat_reg[NAC_IRQ_READ_DONE])
        else $error("status flag not cleared");
    load_event_a: assert property (@(posedge clock) disable iff (!rstN)
        loadDone |=> irqStat_reg[NAC_IRQ_RELOAD_DONE] && !busy)
        else $error("load done flag not set");
    strobe_quiet_a: assert property (@(posedge clock) disable iff (!rstN)
        !wrCmd |=> !cmd.measureStart && !cmd.resultClearArm && !cmd.chargeCountClear
            && !cmd.chargeCalibrationStart && !cmd.defaultsReload && !cmd.fullReset)
        else $error("command strobe without a write");
endmodule
`default_nettype wire

// file: test/nac_nvm_model.sv
// behavioural nvm array seen from the register group
// assumes the same clock as the design; answers while the read request is high
`timescale 1ns/1ps
`default_nettype none
module nac_nvm_model
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       nvmReadReq,
    input  wire logic [6:0] nvmAddr,
    output var logic [7:0]  nvmData
);
    // ************************************************************
    // array answer
    // ************************************************************
    // outside a read the lines toggle, so a stale sample never looks valid
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            nvmData <= 8'hC3;
        else if (nvmReadReq)
            nvmData <= {nvmAddr, 1'b1} ^ 8'h5A;
        else
            nvmData <= ~nvmData;
    end
endmodule
`default_nettype wire

// file: test/tb_nvm_access_and_command_strobes.sv
// self-checking bench for the nvm access and command strobe registers
// assumes the nvm array model; load count shortened for simulation
`timescale 1ns/1ps
`default_nettype none
module tb_nvm_access_and_command_strobes;
    import nac_pkg::*;
    localparam int LOADN = 8;
    logic       clock = 1'b0;
    logic       nrst = 1'b0;
    nac_bus_s   bus = '0;
    logic [7:0] rdata;
    nac_cmd_s   cmd;
    logic       nvmReadReq;
    logic [6:0] nvmAddr;
    logic [7:0] nvmData;
    logic       regsClear;
    logic       defaultsLoading;
    logic       modesHeldOff;
    logic       irq;
    logic [7:0] rd;
    int         mismatches = 0;
    int         n_compared = 0;

    always #25 clock = ~clock;

    nac_regs #(.LOAD_CYCLES(LOADN)) i_dut
    (
        .clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata), .cmd(cmd),
        .nvmReadReq(nvmReadReq), .nvmAddr(nvmAddr), .nvmData(nvmData),
        .regsClear(regsClear), .defaultsLoading(defaultsLoading),
        .modesHeldOff(modesHeldOff), .irq(irq)
    );

    nac_nvm_model i_nvm
    (
        .clock(clock), .nrst(nrst), .nvmReadReq(nvmReadReq),
        .nvmAddr(nvmAddr), .nvmData(nvmData)
    );

    // ************************************************************
    // bus and compare helpers
    // ************************************************************
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        bus <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        bus <= '0;
        @(negedge clock);
        d = rdata;
    endtask

    task automatic rchk(input string w, input logic [7:0] a, input logic [7:0] e);
        rd8(a, rd);
        check(w, rd, e);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_nvm(input logic [6:0] a);
        int polls = 0;
        wr(NAC_ADDR_WORD, {1'b0, a});
        @(negedge clock);
        check("nvm addr", {1'b0, nvmAddr}, {1'b0, a});
        rchk("word addr", NAC_ADDR_WORD, {1'b0, a});
        wr(NAC_ADDR_STAT, 8'h04);
        @(negedge clock);
        check("read request", {7'd0, nvmReadReq}, 8'h01);
        rd8(NAC_ADDR_STAT, rd);
        check("busy", rd, 8'h0C);
        while (rd[NAC_STAT_BUSY_BIT] !== 1'b0 && polls < 20)
        begin
            rd8(NAC_ADDR_STAT, rd);
            polls++;
        end
        check("read done", rd, 8'h00);
        if (polls == 20)
            end_of_test();
        else
            rchk("nvm data", NAC_ADDR_RDATA, {a, 1'b1} ^ 8'h5A);
    endtask

    task automatic t_irq();
        wr(NAC_ADDR_IRQMSK, 8'h00);
        rchk("irq status", NAC_ADDR_IRQST, 8'h01);
        check("irq masked", {7'd0, irq}, 8'h00);
        wr(NAC_ADDR_IRQMSK, 8'h01);
        repeat (2) @(negedge clock);
        check("irq on", {7'd0, irq}, 8'h01);
        wr(NAC_ADDR_IRQST, 8'h01);
        @(negedge clock);
        check("irq off", {7'd0, irq}, 8'h00);
        rchk("irq cleared", NAC_ADDR_IRQST, 8'h00);
        wr(NAC_ADDR_IRQMSK, 8'h00);
    endtask

    task automatic t_cmd(input logic [7:0] b, input logic [5:0] e);
        wr(NAC_ADDR_CMD, b);
        @(negedge clock);
        check("cmd pulse", {2'b00, cmd}, {2'b00, e});
        @(negedge clock);
        check("cmd one cycle", {2'b00, cmd}, 8'h00);
    endtask

    // counts each phase of a reload or a full reset cycle by cycle
    task automatic t_load(input logic [7:0] b, input logic full);
        int nLoad = 0;
        int nClear = 0;
        int nHeld = 0;
        int nPulse = 0;
        int nOther = 0;
        wr(NAC_ADDR_CMD, b);
        repeat (LOADN + 8)
        begin
            @(negedge clock);
            nLoad += defaultsLoading;
            nClear += regsClear;
            nHeld += modesHeldOff;
            nPulse += full ? cmd.fullReset : cmd.defaultsReload;
            nOther += full ? cmd.defaultsReload : cmd.fullReset;
        end
        check("load cycles", 8'(nLoad), 8'(LOADN));
        check("clear cycles", 8'(nClear), {7'd0, full});
        check("held cycles", 8'(nHeld), full ? 8'(LOADN + 1) : 8'h00);
        check("load pulse", 8'(nPulse), 8'h01);
        check("other pulse", 8'(nOther), 8'h00);
        rchk("load done", NAC_ADDR_IRQST, 8'h02);
        wr(NAC_ADDR_IRQST, 8'h02);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        rchk("rdata reset", NAC_ADDR_RDATA, 8'h00);
        rchk("addr reset", NAC_ADDR_WORD, 8'h00);
        rchk("stat reset", NAC_ADDR_STAT, 8'h00);
        rchk("cmd reads zero", NAC_ADDR_CMD, 8'h00);
        rchk("unmapped", 8'h3F, 8'h00);
        t_nvm(7'h7F);
        t_nvm(7'h00);
        t_irq();
        t_cmd(8'h40, 6'b010000);
        t_cmd(8'h80, 6'b100000);
        t_cmd(8'h20, 6'b001000);
        t_cmd(8'h10, 6'b000100);
        t_cmd(8'hF0, 6'b111100);
        rchk("cmd after write", NAC_ADDR_CMD, 8'h00);
        t_load(8'h04, 1'b0);
        wr(NAC_ADDR_WORD, 8'h2A);
        t_load(8'h05, 1'b1);
        rchk("addr cleared", NAC_ADDR_WORD, 8'h00);
        rchk("data cleared", NAC_ADDR_RDATA, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
